// file: hdl/sdr_pkg.sv
// Shared constants and types for the serial diagnosis readout decoder.
// Assumes a 16-bit frame, control byte first, most significant bit first.
package sdr_pkg;

  // Frame geometry
  localparam int          FRAME_BITS = 16;
  localparam logic [4:0]  FRAME_LEN  = 5'h10;
  localparam logic [4:0]  LAST_IDX   = 5'h0F;
  localparam logic [4:0]  CNT_FIRST  = 5'h01;
  localparam int          GRP_CH     = 8;
  localparam int          ALL_CH     = 16;

  // Control byte nibbles
  localparam logic [3:0]  NIB_DIAG   = 4'h0;
  localparam logic [3:0]  NIB_RDBK   = 4'hC;
  localparam logic [3:0]  NIB_ECHO   = 4'hA;
  localparam logic [3:0]  NIB_LOWER  = 4'h0;
  localparam logic [3:0]  NIB_UPPER  = 4'hF;

  // Two-bit diagnosis codes per channel
  localparam logic [1:0]  CODE_OK    = 2'h3;
  localparam logic [1:0]  CODE_OVL   = 2'h2;
  localparam logic [1:0]  CODE_OPEN  = 2'h1;
  localparam logic [1:0]  CODE_GND   = 2'h0;

  // Values after reset
  localparam logic [15:0] REPLY_RST  = 16'h0000;
  localparam logic [31:0] DIAG_RST   = 32'hFFFF_FFFF;
  localparam logic [1:0]  CS_SYNC_RST = 2'h3;
  localparam logic [15:0] PAR_RST    = 16'h0000;

  // Reply mode for the next chip-select cycle, one-hot
  typedef enum logic [3:0] {
    MODE_IDLE = 4'h1,
    MODE_DIAG = 4'h2,
    MODE_RDBK = 4'h4,
    MODE_ECHO = 4'h8
  } sdr_mode_t;

  // Received frame
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] data;
  } sdr_frame_t;

  // Decoded command state handed to the link side
  typedef struct packed {
    sdr_mode_t   mode;
    logic        upper;
    logic [15:0] reply;
  } sdr_cmd_t;

endpackage

// file: hdl/sdr_decoder.sv
// Decoder for the read-only serial commands: diagnosis, read-back, echo.
// Assumes spi_clk idles low, chip select high between frames for at least
// four sys_clk periods, and diag_code driven by logic on sys_clk.
`timescale 1ns/1ps

module sdr_decoder #(
  parameter int GRP = 8
) (
  // System clock and reset
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // Serial link from the host
  input  wire logic        spi_clk,
  input  wire logic        spi_cs_n,
  input  wire logic        spi_si,
  output logic             spi_so,
  output logic             spi_so_oe,
  // Channel side
  input  wire logic [15:0] par_in,
  input  wire logic [31:0] diag_code,
  // Status towards the rest of the chip
  output sdr_pkg::sdr_mode_t reply_mode,
  output logic             reply_upper,
  output logic             cmd_taken,
  output logic             cmd_ignored
);

  // Group size is fixed by the 16-bit frame
  if (GRP != sdr_pkg::GRP_CH) begin : g_chk
    $error("GRP must be 8");
  end

  // Helpers used by store and decode.
  // Channel k occupies code bits 2k+1 down to 2k.
  // Two-bit code of one channel
  function automatic logic [1:0] ch_code(input logic [31:0] v,
                                         input int ch);
    ch_code = v[2*ch +: 2];
  endfunction

  // One-bit healthy flag from a two-bit code, high for CODE_OK
  function automatic logic ok_flag(input logic [1:0] c);
    ok_flag = (c == sdr_pkg::CODE_OK);
  endfunction

  // ---------------------------------------------------------------
  // Link domain, clocked by spi_clk
  // ---------------------------------------------------------------
  // Link-side notes:
  // No system reset reaches this side.
  // Chip select high clears the start flag.
  // Counter and shift word keep their last value.
  // System side reads them only after frame end.
  // Link clock is stopped by then, values settled.
  // Count of sixteen marks a complete frame.
  // Count saturates at sixteen, so long frames pass as complete.
  // Short frames never reach the full count.
  // Echo bit holds the last sampled input.
  // Reply bit index counts down from fifteen.
  logic                started;
  logic                next_started;
  logic [4:0]          bit_cnt;
  logic [4:0]          next_bit_cnt;
  sdr_pkg::sdr_frame_t rx_word;
  sdr_pkg::sdr_frame_t next_rx_word;
  logic                echo_bit;
  logic                next_echo_bit;

  // Decoded state held on the system side, static during a frame
  sdr_pkg::sdr_cmd_t   cmd;
  sdr_pkg::sdr_cmd_t   next_cmd;

  // Next values of the link shift logic
  always_comb begin
    next_started = 1'b1;
    if (!started) begin
      next_bit_cnt = sdr_pkg::CNT_FIRST;
    end else if (bit_cnt == sdr_pkg::FRAME_LEN) begin
      next_bit_cnt = bit_cnt; // Saturate, overlong frame reads as complete
    end else begin
      next_bit_cnt = bit_cnt + sdr_pkg::CNT_FIRST;
    end
    next_rx_word  = {rx_word[14:0], spi_si};
    next_echo_bit = spi_si;
  end

  // Frame-start flag, cleared while chip select is high
  always_ff @(posedge spi_clk or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      started <= 1'b0;
    end else begin
      started <= next_started;
    end
  end

  // Bit counter and shift registers, kept after the frame ends
  always_ff @(posedge spi_clk) begin
    bit_cnt  <= next_bit_cnt;
    rx_word  <= next_rx_word;
    echo_bit <= next_echo_bit;
  end

  // Output notes:
  // First reply bit stands from chip select fall.
  // Each rising edge advances one bit.
  // Host samples just before each rising edge.
  // After the sixteenth edge the pin reads zero.
  // Echo shows input of the last rising edge.
  // Serial output: reply word, or the looped input in echo
  always_comb begin
    spi_so_oe = !spi_cs_n;
    if (cmd.mode == sdr_pkg::MODE_ECHO) begin
      spi_so = started & echo_bit;
    end else if (!started) begin
      spi_so = cmd.reply[15];
    end else if (bit_cnt < sdr_pkg::FRAME_LEN) begin
      spi_so = cmd.reply[4'(sdr_pkg::LAST_IDX - bit_cnt)];
    end else begin
      spi_so = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // System domain, clocked by sys_clk
  // ---------------------------------------------------------------
  // System-side notes:
  // Chip select passes two flip-flops first.
  // Frame end is the settled rising chip select.
  // One further stage, cs_prev, only finds the edge.
  // Decode samples the link registers then.
  // Host must keep chip select high four cycles.
  // Shorter gaps may lose the command pulse.
  // Parallel inputs also pass two flip-flops.
  // Only the second stage feeds the reply.
  logic [1:0]  cs_sync;
  logic [1:0]  next_cs_sync;
  logic        cs_prev;
  logic        next_cs_prev;
  logic [15:0] par_meta;
  logic [15:0] par_sync;
  logic        frame_end;

  // Synchronisers for chip select and the parallel inputs
  always_comb begin
    next_cs_sync = {cs_sync[0], spi_cs_n};
    next_cs_prev = cs_sync[1];
    frame_end    = cs_sync[1] & !cs_prev; // Rising chip select
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      cs_sync  <= sdr_pkg::CS_SYNC_RST;
      cs_prev  <= 1'b1;
      par_meta <= sdr_pkg::PAR_RST;
      par_sync <= sdr_pkg::PAR_RST;
    end else begin
      cs_sync  <= next_cs_sync;
      cs_prev  <= next_cs_prev;
      par_meta <= par_in;
      par_sync <= par_meta;
    end
  end

  // Stored diagnosis, two bits per channel
  logic [31:0] diag_store;
  logic [31:0] next_diag_store;
  logic        clr_en;

  // Diagnosis store notes:
  // Each channel keeps its first fault code.
  // A healthy channel follows the live code.
  // Clear reloads the group from the live code.
  // So a fault present at the clear survives.
  // Only the group of the read reply clears.
  // Echo and idle replies clear nothing.
  // Latch first fault, clear the group just read out
  always_comb begin
    clr_en = frame_end & ((cmd.mode == sdr_pkg::MODE_DIAG) |
                          (cmd.mode == sdr_pkg::MODE_RDBK));
    next_diag_store = diag_store;
    for (int ch = 0; ch < sdr_pkg::ALL_CH; ch++) begin
      if ((clr_en && ((ch >= GRP) == cmd.upper)) ||
          ok_flag(ch_code(diag_store, ch))) begin
        // New fault wins over the clear
        next_diag_store[2*ch +: 2] = ch_code(diag_code, ch);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      diag_store <= sdr_pkg::DIAG_RST;
    end else begin
      diag_store <= next_diag_store;
    end
  end

  // Decode notes:
  // Reply word is built once, at frame end.
  // It then stays fixed through the next frame.
  // Link side reads it as a static word.
  // Unknown control bytes give an idle reply.
  // Frame after echo is a loop frame only.
  // Its content is never decoded.
  // Data byte is ignored by every command.
  // Lowest channel sits in the lowest bits.
  // Command decode at the end of each frame
  logic       next_taken;
  logic       next_ignored;
  logic [3:0] hi_nib;
  logic [3:0] lo_nib;
  logic       grp_ok;
  logic       grp_up;
  int         src;

  always_comb begin
    next_cmd     = cmd;
    next_taken   = 1'b0;
    next_ignored = 1'b0;
    hi_nib       = rx_word.ctrl[7:4];
    lo_nib       = rx_word.ctrl[3:0];
    grp_ok       = (lo_nib == sdr_pkg::NIB_LOWER) |
                   (lo_nib == sdr_pkg::NIB_UPPER);
    grp_up       = (lo_nib == sdr_pkg::NIB_UPPER);
    src          = 0;
    if (frame_end) begin
      // Default: nothing pending, output reads zero
      next_cmd.mode  = sdr_pkg::MODE_IDLE;
      next_cmd.upper = 1'b0;
      next_cmd.reply = sdr_pkg::REPLY_RST;
      if (bit_cnt != sdr_pkg::FRAME_LEN) begin
        next_ignored = 1'b1;
      end else if (cmd.mode == sdr_pkg::MODE_ECHO) begin
        // Echo frame carries no command
        next_taken = 1'b0;
      end else if (grp_ok && hi_nib == sdr_pkg::NIB_DIAG) begin
        next_taken     = 1'b1;
        next_cmd.mode  = sdr_pkg::MODE_DIAG;
        next_cmd.upper = grp_up;
        for (int k = 0; k < GRP; k++) begin
          src = grp_up ? k + GRP : k;
          next_cmd.reply[2*k +: 2] = ch_code(diag_store, src);
        end
      end else if (grp_ok && hi_nib == sdr_pkg::NIB_RDBK) begin
        next_taken     = 1'b1;
        next_cmd.mode  = sdr_pkg::MODE_RDBK;
        next_cmd.upper = grp_up;
        for (int k = 0; k < GRP; k++) begin
          src = grp_up ? k + GRP : k;
          next_cmd.reply[k + GRP] = par_sync[src];
          next_cmd.reply[k] = ok_flag(ch_code(diag_store, src));
        end
      end else if (grp_ok && hi_nib == sdr_pkg::NIB_ECHO) begin
        next_taken    = 1'b1;
        next_cmd.mode = sdr_pkg::MODE_ECHO;
      end else begin
        next_ignored = 1'b1;
      end
    end
  end

  // Reset notes:
  // Reset gives the idle reply, both pulses low.
  // Stored diagnosis resets to all healthy.
  // Link logic needs no reset of its own.
  // Command state and status pulses
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      cmd.mode    <= sdr_pkg::MODE_IDLE;
      cmd.upper   <= 1'b0;
      cmd.reply   <= sdr_pkg::REPLY_RST;
      cmd_taken   <= 1'b0;
      cmd_ignored <= 1'b0;
    end else begin
      cmd         <= next_cmd;
      cmd_taken   <= next_taken;
      cmd_ignored <= next_ignored;
    end
  end

  // Status notes:
  // Pulses last one system clock each.
  // Taken and ignored never rise together.
  // Mode and group change only between frames.
  // Outside logic may watch them freely.
  // Status copies of the pending reply
  always_comb begin
    reply_mode  = cmd.mode;
    reply_upper = cmd.upper;
  end

endmodule

// file: test/sdr_decoder_sva.sv
// Port assertions for the readout decoder, bound into each instance.
// Assumes the host changes SI only at falling link clock edges.
`timescale 1ns/1ps
module sdr_chk (
  // Clocks and reset
  input wire logic               sys_clk,
  input wire logic               nrst,
  input wire logic               spi_clk,
  // Serial link
  input wire logic               spi_cs_n,
  input wire logic               spi_si,
  input wire logic               spi_so,
  input wire logic               spi_so_oe,
  // Status
  input wire sdr_pkg::sdr_mode_t reply_mode,
  input wire logic               reply_upper,
  input wire logic               cmd_taken,
  input wire logic               cmd_ignored
);
  // Pin enable and status pulses
  a_oe_follows_cs:
    assert property (@(posedge sys_clk) disable iff (!nrst)
      spi_so_oe == !spi_cs_n) else $error("so enable wrong");
  a_taken_single:
    assert property (@(posedge sys_clk) disable iff (!nrst)
      cmd_taken |=> !cmd_taken) else $error("taken pulse too long");
  a_pulse_exclusive:
    assert property (@(posedge sys_clk) disable iff (!nrst)
      !(cmd_taken && cmd_ignored)) else $error("taken and ignored");
  // Pending reply mode
  a_mode_onehot:
    assert property (@(posedge sys_clk) disable iff (!nrst)
      $onehot(reply_mode)) else $error("mode not one-hot");
  a_mode_between_frames:
    assert property (@(posedge sys_clk) disable iff (!nrst)
      $changed({reply_mode, reply_upper}) |-> spi_cs_n)
      else $error("mode changed inside frame");
  a_taken_sets_mode:
    assert property (@(posedge sys_clk) disable iff (!nrst)
      cmd_taken |-> ##[0:2] reply_mode != sdr_pkg::MODE_IDLE)
      else $error("taken without mode");
  a_ignored_idles:
    assert property (@(posedge sys_clk) disable iff (!nrst)
      cmd_ignored |-> ##[0:2] reply_mode == sdr_pkg::MODE_IDLE)
      else $error("ignored frame left a mode");
  // Loop-back path on the link clock
  a_echo_loop:
    assert property (@(negedge spi_clk) disable iff (spi_cs_n)
      reply_mode == sdr_pkg::MODE_ECHO |-> spi_so == spi_si)
      else $error("echo output differs");
  c_taken: cover property (@(posedge sys_clk) cmd_taken);
  c_ignored: cover property (@(posedge sys_clk) cmd_ignored);
  c_echo: cover property (@(posedge sys_clk)
    reply_mode == sdr_pkg::MODE_ECHO);
endmodule

bind sdr_decoder sdr_chk u_chk (.sys_clk, .nrst, .spi_clk, .spi_cs_n,
  .spi_si, .spi_so, .spi_so_oe, .reply_mode, .reply_upper, .cmd_taken,
  .cmd_ignored);

// file: test/sdr_host.sv
// Host model acting as serial master of the link.
// Assumes the decoder samples SI on rising link clock edges.
`timescale 1ns/1ps
module sdr_host (
  // Serial link
  output logic      spi_clk,
  output logic      spi_cs_n,
  output logic      spi_si,
  input  wire logic spi_so
);
  // Idle link: clock low, chip select high
  initial begin
    spi_clk = 1'h0;
    spi_cs_n = 1'h1;
    spi_si = 1'h0;
  end
  // Frame of n bits, MSB first, 32 ns clock; reply caught before each
  // rising edge
  task automatic frame(input logic [15:0] tx, input int n,
                       output logic [15:0] rx);
    rx = '0;
    spi_cs_n = 1'h0;
    for (int i = 0; i < n; i++) begin
      spi_si = tx[15-i];
      #16 rx = {rx[14:0], spi_so};
      spi_clk = 1'h1;
      #16 spi_clk = 1'h0;
    end
    #16 spi_cs_n = 1'h1;
    // Released data line shows the inverse of its last bit
    spi_si = ~spi_si;
  endtask
endmodule

// file: test/sdr_decoder_tb.sv
// Self-checking bench for the decoder, host model on the link.
// Assumes the design, checker and host model are compiled first.
`timescale 1ns/1ps
module sdr_decoder_tb;
  logic               sys_clk = 1'h0, nrst = 1'h0, reply_upper, t, g;
  logic               cmd_taken, cmd_ignored;
  logic [15:0]        par_in = '0, rx, tx;
  logic [31:0]        diag_code = '1, st = '1;
  wire                spi_clk, spi_cs_n, spi_si, spi_so;
  sdr_pkg::sdr_mode_t reply_mode;
  int                 errors = 0, n_compared = 0, seed = 55415, k;
  logic [7:0]         ctl [8] = '{8'h00, 8'h0F, 8'hC0, 8'hCF, 8'hA0,
                                  8'hAF, 8'h33, 8'h00};

  // System clock
  always #20 sys_clk = ~sys_clk;

  sdr_decoder DUT (.sys_clk, .nrst, .spi_clk, .spi_cs_n, .spi_si, .spi_so,
    .spi_so_oe(), .par_in, .diag_code, .reply_mode, .reply_upper,
    .cmd_taken, .cmd_ignored);
  sdr_host host (.spi_clk, .spi_cs_n, .spi_si, .spi_so);

  // Compare and count
  task automatic check(string nm, logic [15:0] got, logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic finish_test;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Reply expected for table entry k, read out while sending tx
  function automatic logic [15:0] expect_reply(int k, logic [15:0] tx);
    logic [15:0] r;
    int          b;
    r = '0;
    b = k % 2 * 8;
    if (k < 2) r = st[b*2 +: 16];
    else if (k < 4)
      for (int c = 0; c < 8; c++) begin
        r[8+c] = par_in[b+c];
        r[c] = &st[2*(b+c) +: 2];
      end
    else if (k < 6) r = {1'h0, tx[15:1]};
    return r;
  endfunction

  // Command frame, status pulses, then the reply frame
  initial begin
    repeat (6) @(posedge sys_clk);
    #1 nrst = 1'h1;
    repeat (4) @(posedge sys_clk);
    for (int i = 0; i < 24; i++) begin
      k = i < 8 ? i : $unsigned($random(seed)) % 8;
      #1 par_in = 16'($random(seed));
      diag_code = $random(seed);
      for (int c = 0; c < 32; c += 2)
        if (&st[c +: 2]) st[c +: 2] = diag_code[c +: 2];
      tx = {ctl[k], 8'($random(seed))};
      host.frame(tx, k == 7 ? 15 : 16, rx);
      check("idle reply", rx, '0);
      t = 1'h0;
      g = 1'h0;
      repeat (8) begin
        @(posedge sys_clk);
        #1 t |= cmd_taken;
        g |= cmd_ignored;
      end
      check("pulses", 16'({t, g}), k < 6 ? 16'h0002 : 16'h0001);
      check("mode", 16'(reply_mode), k < 6 ? 16'(4'h2 << k / 2) :
        16'h0001);
      if (k < 4) check("upper", 16'(reply_upper), 16'(k % 2));
      tx = {8'h33, 8'($random(seed))};
      #($unsigned($random(seed)) % 300);
      host.frame(tx, 16, rx);
      check("reply", rx, expect_reply(k, tx));
      if (k < 4) st[k%2*16 +: 16] = diag_code[k%2*16 +: 16];
      repeat (8) @(posedge sys_clk);
    end
    finish_test;
  end

  // Watchdog against a hang
  initial begin
    #400000;
    errors++;
    finish_test;
  end
endmodule
